// File: rtl/dcs_top.sv
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "dcs_map.svh"
// Behaviour
// - Enable bit powers converter; wait reference settling
// - Analog-to-digital conversion lasts 13 converter cycles
// - Sample in third cycle, hold afterwards
// - At end set done flag, store result
// - Done visible one converter cycle later
// - Result stable until next end; read-only
// - Channel six: select supply or temperature
// - Supply channel presents supply over eight
// - Output mode needs enable and mode bits
// - Output mode ignores differential_select, connect, channel
// - Output mode forces two pins input-only
// - Output conversion lasts 11 cycles, sets done
// - Build from cycle two, output cycle seven
// - Data registers write-only in output mode
// - Copy data to buffer at start
// - Default clock is internal 2 MHz
// - Alternative clock from 7-bit prescaler
// - Start bit runs one conversion, self-clears
// - Timer overflow starts conversion, sets busy
// - Differential_select bit picks single-ended or differential
// - Two's complement, sign-extend or zero-fill
module dcs_top (
   input  wire logic              core_clk,
   input  wire logic              arst_n,
   input  wire logic [11:0]       s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [11:0]       s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic [2:0]        tmr_ovf,
   input  wire logic              comp_in,
   output dcs_pkg::dcs_amux_t     amux,
   output logic                   analog_pwr,
   output logic                   sample_track,
   output logic [9:0]             trial_code,
   output logic [9:0]             dac_code,
   output logic                   dac_pins_input_only
);
   import dcs_pkg::*;

   // ----------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------
   logic [7:0]  ctrl_cfg;      // Mode, enable, adjust, clock select
   logic        done_flag;     // Conversion done, sticky
   logic        busy;          // Start/busy bit
   logic [7:0]  input_cfg;     // Channel, differential_select, source, trigger
   logic [7:0]  data_hi;       // Output value, high byte
   logic [7:0]  data_lo;       // Output value, low byte
   logic [15:0] result;        // Formatted conversion result
   dcs_state_t  state;         // Sequencer state
   logic [3:0]  cnt;           // Current converter cycle number
   logic [15:0] settle_cnt;    // Reference settling timer
   logic [9:0]  dac_buf;       // Output value frozen per conversion
   logic        is_dac;        // Mode latched at start
   logic [4:0]  int_div;       // Internal 2 MHz divider
   logic [6:0]  presc;         // Free prescaler
   logic [2:0]  comp_sync;     // Comparator synchroniser
   logic        comp;          // Filtered comparator level
   logic        wr_go;         // Write that sets the start bit

   logic        en;
   logic        dac_mode;
   logic [2:0]  ack;
   logic [6:0]  ack_mask;
   logic        tick;
   logic        trig;
   logic [3:0]  last_cyc;
   logic [3:0]  sar_idx;
   logic [9:0]  trial_next;
   logic [9:0]  signed_res;

   assign en       = ctrl_cfg[`DCS_C_EN];
   // Output mode needs both bits
   assign dac_mode = en & ctrl_cfg[`DCS_C_DAC];
   assign ack      = ctrl_cfg[`DCS_C_ACK_HI:0];
   assign analog_pwr = en;

   // ----------------------------------------------------------------
   // Converter clock tick
   // ----------------------------------------------------------------
   // Internal divider stands in for the 2 MHz source and runs
   // whether or not the system clock comes from it
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         int_div <= 5'h0_0;
      end else if (int_div == 5'(`DCS_INT_DIV - 1)) begin
         int_div <= 5'h0_0;
      end else begin
         int_div <= int_div + 5'h0_1;
      end
   end

   // Prescaler counts system clocks; not affected by CPU division
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         presc <= 7'h0_0;
      end else begin
         presc <= presc + 7'h0_1;
      end
   end

   // Select n from 1 to 7 gives oscillator / 2^n; select 0 gives the internal 2 MHz
   assign ack_mask = 7'((8'h0_1 << ack) - 8'h0_1);
   always_comb begin
      if (ack == 3'h0) begin
         tick = (int_div == 5'(`DCS_INT_DIV - 1));
      end else begin
         tick = &(presc | ~ack_mask);
      end
   end

   // ----------------------------------------------------------------
   // Comparator input synchroniser
   // ----------------------------------------------------------------
   // Only stages two and three are looked at
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         comp_sync <= 3'h0;
         comp      <= 1'b0;
      end else begin
         comp_sync <= {comp_sync[1:0], comp_in};
         if (comp_sync[1] == comp_sync[2]) begin
            comp <= comp_sync[2];
         end
      end
   end

   // ----------------------------------------------------------------
   // Start sources
   // ----------------------------------------------------------------
   // Timer select 0 means software only
   always_comb begin
      case (input_cfg[`DCS_I_TRG_HI:`DCS_I_TRG_LO])
         2'h1:    trig = tmr_ovf[0];
         2'h2:    trig = tmr_ovf[1];
         2'h3:    trig = tmr_ovf[2];
         default: trig = 1'b0;
      endcase
   end

   assign last_cyc = is_dac ? `DCS_DAC_CYC : `DCS_ADC_CYC;

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   // A start waits in busy until the next converter tick
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state      <= DCS_OFF;
         settle_cnt <= 16'h0000;
         cnt        <= 4'h0;
      end else if (!en) begin
         state <= DCS_OFF;
         cnt   <= 4'h0;
      end else begin
         case (state)
            DCS_OFF: begin
               state      <= DCS_SETTLE;
               settle_cnt <= 16'h0000;
            end
            DCS_SETTLE: begin
               // Starts are held until references settle
               if (settle_cnt == 16'(`DCS_SETTLE_CYC - 1)) begin
                  state <= DCS_IDLE;
               end else begin
                  settle_cnt <= settle_cnt + 16'h0001;
               end
            end
            DCS_IDLE: begin
               if (busy && tick) begin
                  state <= DCS_CONV;
                  cnt   <= 4'h1;
               end
            end
            DCS_CONV: begin
               if (tick) begin
                  if (cnt == last_cyc) begin
                     state <= DCS_SYNC;
                  end else begin
                     cnt <= cnt + 4'h1;
                  end
               end
            end
            DCS_SYNC: begin
               // One extra converter cycle before the flag shows
               if (tick) begin
                  state <= DCS_IDLE;
                  cnt   <= 4'h0;
               end
            end
            default: state <= DCS_OFF;
         endcase
      end
   end

   // Mode and output value frozen at the start of each conversion
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         is_dac  <= 1'b0;
         dac_buf <= 10'h000;
      end else if (state == DCS_IDLE && busy && tick) begin
         is_dac  <= dac_mode;
         dac_buf <= {data_hi[1:0], data_lo};
      end
   end

   // ----------------------------------------------------------------
   // Successive approximation and output update
   // ----------------------------------------------------------------
   assign sar_idx = `DCS_ADC_CYC - cnt;
   always_comb begin
      trial_next = trial_code;
      if (!comp) begin
         trial_next[sar_idx] = 1'b0;
      end
      if (sar_idx != 4'h0) begin
         trial_next[sar_idx - 4'h1] = 1'b1;
      end
   end

   // Input held after cycle three; bits decided in cycles 4..13
   assign sample_track = (state == DCS_CONV) && !is_dac &&
                         (cnt == `DCS_SAMPLE_CYC);

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         trial_code <= 10'h000;
      end else if (state == DCS_CONV && !is_dac && tick) begin
         if (cnt == `DCS_SAMPLE_CYC) begin
            trial_code <= `DCS_MSB_TRIAL;
         end else if (cnt >= `DCS_SAR_FIRST) begin
            trial_code <= trial_next;
         end
      end
   end

   // Construction runs internally from cycle two; pins see the
   // new value from cycle seven once the top five bits are set
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         dac_code <= 10'h000;
      end else if (state == DCS_CONV && is_dac && tick &&
                   cnt == `DCS_DAC_PROP - 4'h1) begin
         dac_code <= dac_buf;
      end
   end

   // Offset binary to two's complement, then adjust
   assign signed_res = trial_next ^ `DCS_MSB_TRIAL;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         result <= 16'h0000;
      end else if (state == DCS_CONV && !is_dac && tick &&
                   cnt == `DCS_ADC_CYC) begin
         if (ctrl_cfg[`DCS_C_LEFT_ADJUST_BIT]) begin
            result <= {signed_res, 6'h00};
         end else begin
            result <= {{6{signed_res[9]}}, signed_res};
         end
      end
   end

   // ----------------------------------------------------------------
   // Analog routing
   // ----------------------------------------------------------------
   // Front-end selection is parked in output mode
   always_comb begin
      amux = '0;
      if (en && !dac_mode) begin
         amux.connect = input_cfg[`DCS_I_CONN];
         amux.differential_select    = input_cfg[`DCS_I_DIFFERENTIAL_SELECT];
         amux.chan    = input_cfg[`DCS_I_CH_HI:0];
         if (amux.chan == `DCS_CH_INT) begin
            amux.int_ref  = 1'b1;
            amux.temp     = input_cfg[`DCS_I_INTERNAL_SOURCE_SELECT];
            amux.sup_div8 = !input_cfg[`DCS_I_INTERNAL_SOURCE_SELECT];
         end
      end
   end
   assign dac_pins_input_only = dac_mode;

   // ----------------------------------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------------------------------
   logic        aw_held;
   logic        w_held;
   logic [11:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        wr_do;
   logic        wr_ok;
   logic        wr_ctrl;
   logic        wr_end;

   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign wr_do   = aw_held && w_held;
   assign wr_ok   = (aw_addr == `DCS_OFF_CTRL) ||
                    (aw_addr == `DCS_OFF_INPUT) ||
                    (aw_addr == `DCS_OFF_DATAH) ||
                    (aw_addr == `DCS_OFF_DATAL);
   assign wr_ctrl = wr_do && w_strb[0] && (aw_addr == `DCS_OFF_CTRL);
   assign wr_go   = wr_ctrl && w_data[`DCS_C_BUSY] && en;
   assign wr_end  = (state == DCS_CONV) && tick && (cnt == last_cyc);

   // Address and data are taken in either order
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         aw_addr      <= 12'h000;
         w_data       <= 32'h0000_0000;
         w_strb       <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `DCS_RESP_OK;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= {s_axi_awaddr[11:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_do) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? `DCS_RESP_OK : `DCS_RESP_ERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Configuration bytes; only byte lane 0 is implemented
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_cfg  <= `DCS_RST_BYTE;
         input_cfg <= `DCS_RST_BYTE;
      end else if (wr_do && w_strb[0]) begin
         if (aw_addr == `DCS_OFF_CTRL) begin
            ctrl_cfg <= {2'h0, w_data[`DCS_C_DAC:0]};
         end else if (aw_addr == `DCS_OFF_INPUT) begin
            input_cfg <= w_data[7:0];
         end
      end
   end

   // Data bytes take writes only in output mode
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         data_hi <= `DCS_RST_BYTE;
         data_lo <= `DCS_RST_BYTE;
      end else if (wr_do && w_strb[0] && dac_mode) begin
         if (aw_addr == `DCS_OFF_DATAH) begin
            data_hi <= w_data[7:0];
         end else if (aw_addr == `DCS_OFF_DATAL) begin
            data_lo <= w_data[7:0];
         end
      end
   end

   // Busy: set by software or timer, cleared with done at the end of the sync cycle after cycle N
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         busy <= 1'b0;
      end else if (!en) begin
         busy <= 1'b0;
      end else if (wr_go) begin
         busy <= 1'b1;
      end else if (trig && !busy) begin
         busy <= 1'b1;
      end else if (state == DCS_SYNC && tick) begin
         busy <= 1'b0;
      end
   end

   // Done: a set in the clearing cycle wins over the clear
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         done_flag <= 1'b0;
      end else if (state == DCS_SYNC && tick) begin
         done_flag <= 1'b1;
      end else if (wr_ctrl && !w_data[`DCS_C_DONE]) begin
         done_flag <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------------------------------
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `DCS_RESP_OK;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= `DCS_RESP_OK;
         s_axi_rdata  <= 32'h0000_0000;
         if (s_axi_araddr[11:2] == `DCS_OFF_CTRL >> 2) begin
            s_axi_rdata[7:0] <= {done_flag, busy, ctrl_cfg[5:0]};
         end else if (s_axi_araddr[11:2] == `DCS_OFF_INPUT >> 2) begin
            s_axi_rdata[7:0] <= input_cfg;
         end else if (s_axi_araddr[11:2] == `DCS_OFF_DATAH >> 2) begin
            // Output mode hides the data registers
            s_axi_rdata[7:0] <= dac_mode ? 8'h00 : result[15:8];
         end else if (s_axi_araddr[11:2] == `DCS_OFF_DATAL >> 2) begin
            s_axi_rdata[7:0] <= dac_mode ? 8'h00 : result[7:0];
         end else begin
            s_axi_rresp <= `DCS_RESP_ERR;
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   property p_off_idle;
      @(posedge core_clk) disable iff (!arst_n)
      !en |=> (state == DCS_OFF) && !busy;
   endproperty
   a_off_idle: assert property (p_off_idle)
      else $error("converter active while disabled");

   property p_adc_len;
      @(posedge core_clk) disable iff (!arst_n)
      (state == DCS_CONV) |-> (cnt <= last_cyc) && (cnt != 4'h0);
   endproperty
   a_adc_len: assert property (p_adc_len)
      else $error("conversion cycle count out of range");

   property p_end_sync;
      @(posedge core_clk) disable iff (!arst_n)
      (wr_end && en) |=> (state == DCS_SYNC) && busy;
   endproperty
   a_end_sync: assert property (p_end_sync)
      else $error("conversion end not followed by sync");

   property p_done_set;
      @(posedge core_clk) disable iff (!arst_n)
      // A start written in the same cycle legally keeps busy up
      (state == DCS_SYNC && tick && en && !wr_go) |=> done_flag && !busy;
   endproperty
   a_done_set: assert property (p_done_set)
      else $error("done flag or busy wrong after sync");

   property p_res_hold;
      @(posedge core_clk) disable iff (!arst_n)
      !(state == DCS_CONV && tick && cnt == `DCS_ADC_CYC && !is_dac)
      |=> $stable(result);
   endproperty
   a_res_hold: assert property (p_res_hold)
      else $error("result changed outside conversion end");

   property p_pins;
      @(posedge core_clk) disable iff (!arst_n)
      dac_mode |-> dac_pins_input_only && !amux.connect;
   endproperty
   a_pins: assert property (p_pins)
      else $error("output pins not forced in output mode");

   property p_buf_hold;
      @(posedge core_clk) disable iff (!arst_n)
      (state == DCS_CONV) ##1 (state == DCS_CONV) |-> $stable(dac_buf);
   endproperty
   a_buf_hold: assert property (p_buf_hold)
      else $error("output buffer changed mid conversion");

   property p_no_start;
      @(posedge core_clk) disable iff (!arst_n)
      (wr_ctrl && !en && !busy) |=> !busy;
   endproperty
   a_no_start: assert property (p_no_start)
      else $error("start accepted while disabled");
endmodule

// File: rtl/dcs_map.svh
`ifndef DCS_MAP_SVH
`define DCS_MAP_SVH
// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define DCS_OFF_CTRL   12'h000
`define DCS_OFF_INPUT  12'h004
`define DCS_OFF_DATAH  12'h008
`define DCS_OFF_DATAL  12'h00C
// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define DCS_C_DONE     7
`define DCS_C_BUSY     6
`define DCS_C_DAC      5
`define DCS_C_EN       4
`define DCS_C_LEFT_ADJUST_BIT     3
`define DCS_C_ACK_HI   2
// ----------------------------------------------------------------
// Input register fields
// ----------------------------------------------------------------
`define DCS_I_CONN     7
`define DCS_I_TRG_HI   6
`define DCS_I_TRG_LO   5
`define DCS_I_INTERNAL_SOURCE_SELECT     4
`define DCS_I_DIFFERENTIAL_SELECT     3
`define DCS_I_CH_HI    2
`define DCS_CH_INT     3'h6
// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define DCS_RST_BYTE   8'h00
`define DCS_CLK_MHZ    40
`define DCS_INT_MHZ    2
`define DCS_INT_DIV    (`DCS_CLK_MHZ / `DCS_INT_MHZ)
`define DCS_SETTLE_US  10
`define DCS_SETTLE_CYC (`DCS_SETTLE_US * `DCS_CLK_MHZ)
`define DCS_ADC_CYC    4'hD
`define DCS_DAC_CYC    4'hB
`define DCS_SAMPLE_CYC 4'h3
`define DCS_SAR_FIRST  4'h4
`define DCS_DAC_PROP   4'h7
`define DCS_MSB_TRIAL  10'h200
`define DCS_RESP_OK    2'b00
`define DCS_RESP_ERR   2'b10
`endif

// File: rtl/dcs_pkg.sv
package dcs_pkg;
   // Sequencer states
   typedef enum logic [2:0] {
      DCS_OFF, DCS_SETTLE, DCS_IDLE, DCS_CONV, DCS_SYNC
   } dcs_state_t;
   // Analog front-end selection, one bundle
   typedef struct packed {
      logic       connect;  // Input pins joined to converter
      logic       differential_select;     // Differential pair selected
      logic       int_ref;  // Internal reference in use
      logic       sup_div8; // Supply divided by eight routed
      logic       temp;     // Temperature sensor routed
      logic [2:0] chan;     // Pin channel number
   } dcs_amux_t;
endpackage

// File: tb/dcs_ana_model.sv
`timescale 1ns/10ps
// Comparator: holds the level sampled while tracking, then compares
module dcs_ana_model (
   input  wire logic       core_clk,
   input  wire logic       sample_track,
   input  wire logic [9:0] trial_code,
   input  wire logic [9:0] vin,
   output logic            comp_in
);
   logic [9:0] held = 10'h000; // Held input level
   // Track only in the sample cycle; later input moves are not seen
   always_ff @(posedge core_clk) begin
      if (sample_track) begin
         held <= vin;
      end
   end
   assign comp_in = (held >= trial_code);
endmodule

// File: tb/data_converter_sequencer_tb.sv
`timescale 1ns/10ps
`include "dcs_map.svh"
module data_converter_sequencer_tb;
   import dcs_pkg::*;
   logic        core_clk, arst_n, awvalid, awready, wvalid, wready;
   logic        bvalid, arvalid, arready, rvalid, comp_in, pwr, samp, pin;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [1:0]  bresp, rresp, rs, trigger_source_select;
   logic [2:0]  tmr_ovf, ch, ck;
   logic [9:0]  trial, dac_code, vin, v;
   logic [15:0] res;
   logic [7:0]  icfg;
   logic        dif;
   dcs_amux_t   amux;
   int          err_total, n_checks, cyc, per;
   dcs_top dut (.core_clk(core_clk), .arst_n(arst_n), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_rready(1'b1),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .tmr_ovf(tmr_ovf), .comp_in(comp_in),
      .amux(amux), .analog_pwr(pwr), .sample_track(samp),
      .trial_code(trial), .dac_code(dac_code), .dac_pins_input_only(pin));
   dcs_ana_model ana (.core_clk(core_clk), .sample_track(samp),
      .trial_code(trial), .vin(vin), .comp_in(comp_in));
   // System clocks since the input was last held by the sampler
   always @(posedge core_clk) cyc <= samp ? 0 : cyc + 1;
   // Free-running system clock
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   task automatic final_report;
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Bounds every wait; a hang ends the run
   task automatic guard(inout int n);
      n++;
      if (n > 2000) begin
         err_total++;
         final_report();
      end
   endtask
   // Ready is sampled mid-cycle, equal to its value at the next edge
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic ta, tw, tb;
      int   n;
      n = 0;
      tb = 1'b0;
      awaddr <= a; wdata <= {24'h00_0000, d}; awvalid <= 1'b1; wvalid <= 1'b1;
      while (!tb) begin
         @(negedge core_clk);
         ta = awvalid & awready; tw = wvalid & wready; tb = bvalid;
         @(posedge core_clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         guard(n);
      end
   endtask
   task automatic rd_reg(input logic [11:0] a);
      logic ta, tr;
      int   n;
      n = 0;
      tr = 1'b0;
      araddr <= a; arvalid <= 1'b1;
      while (!tr) begin
         @(negedge core_clk);
         ta = arvalid & arready; tr = rvalid; rd = rdata; rs = rresp;
         @(posedge core_clk);
         if (ta) arvalid <= 1'b0;
         guard(n);
      end
   endtask
   task automatic wait_idle;
      int n;
      n = 0;
      do begin
         rd_reg(`DCS_OFF_CTRL);
         guard(n);
      end while (rd[6] !== 1'b0);
   endtask
   // Pins are disconnected around every change of the input selection
   task automatic set_in(input logic [7:0] d);
      wr(`DCS_OFF_INPUT, {1'b0, icfg[6:0]});
      wr(`DCS_OFF_INPUT, {1'b0, d[6:0]});
      wr(`DCS_OFF_INPUT, d);
      icfg = d;
   endtask
   // Main sequence
   initial begin
      arst_n = 1'b0; awvalid = 1'b0; wvalid = 1'b0; arvalid = 1'b0;
      awaddr = 12'h000; araddr = 12'h000; wdata = 32'h0000_0000;
      tmr_ovf = 3'h0; vin = 10'h000; err_total = 0; n_checks = 0;
      icfg = 8'h00;
      void'($urandom(32'h3c86));
      repeat (2) @(posedge core_clk);
      arst_n <= 1'b1;
      @(posedge core_clk);
      rd_reg(`DCS_OFF_CTRL); chk(rd, 32'h0000_0000);
      rd_reg(`DCS_OFF_INPUT); chk(rd, 32'h0000_0000);
      rd_reg(12'h010); chk(rs, `DCS_RESP_ERR);
      wr(`DCS_OFF_CTRL, 8'h40); rd_reg(`DCS_OFF_CTRL); chk(rd, 0);
      wr(`DCS_OFF_CTRL, 8'h10); chk(pwr, 1'b1);
      repeat (420) @(posedge core_clk);
      // Conversions: both adjusts, software and each timer trigger
      for (int i = 0; i < 6; i++) begin
         ch = 3'($urandom_range(5, 0)); v = 10'($urandom_range(1023, 0));
         dif = 1'($urandom);
         // One run on the prescaler, the rest on the internal 2 MHz
         ck = (i == 2) ? 3'h5 : 3'h0;
         per = (ck == 3'h0) ? `DCS_INT_DIV : (1 << ck);
         per = per * (`DCS_ADC_CYC - `DCS_SAMPLE_CYC + 1);
         vin <= v;
         trigger_source_select = (i < 3) ? 2'h0 : 2'(i - 2);
         set_in({1'b1, trigger_source_select, 1'b0, dif, ch});
         chk({amux.connect, amux.differential_select, amux.chan}, {1'b1, dif, ch});
         if (trigger_source_select == 2'h0) wr(`DCS_OFF_CTRL, {4'h5, i[0], ck});
         else begin
            wr(`DCS_OFF_CTRL, {4'h1, i[0], ck});
            // Single overflow per conversion keeps the rate slow enough
            tmr_ovf <= 3'(1 << (trigger_source_select - 1));
            @(posedge core_clk);
            tmr_ovf <= 3'h0;
            rd_reg(`DCS_OFF_CTRL); chk(rd[6], 1'b1);
         end
         wait_idle(); chk(rd[7], 1'b1);
         // Cycles four to thirteen plus the flag's extra cycle
         chk(32'(cyc >= per && cyc <= per + 4), 1);
         res = {{6{~v[9]}}, ~v[9], v[8:0]};
         if (i[0]) res = {~v[9], v[8:0], 6'h00};
         rd_reg(`DCS_OFF_DATAH); chk(rd, res[15:8]);
         rd_reg(`DCS_OFF_DATAL); chk(rd, res[7:0]);
         wr(`DCS_OFF_DATAH, 8'hA5);
         rd_reg(`DCS_OFF_DATAH); chk(rd, res[15:8]);
      end
      set_in(8'h86);
      chk({amux.int_ref, amux.sup_div8, amux.temp}, 3'b110);
      set_in(8'h96);
      chk({amux.int_ref, amux.sup_div8, amux.temp}, 3'b101);
      // Output mode: buffer taken at start, later writes not seen
      wr(`DCS_OFF_CTRL, 8'h30); chk(pin, 1'b1);
      chk(amux, 8'h00);
      repeat (420) @(posedge core_clk);
      v = 10'($urandom_range(1023, 0));
      wr(`DCS_OFF_DATAH, {6'h00, v[9:8]}); wr(`DCS_OFF_DATAL, v[7:0]);
      // Clock select 0 keeps the converter clock below the system clock
      wr(`DCS_OFF_CTRL, 8'h70);
      repeat (60) @(posedge core_clk);
      wr(`DCS_OFF_DATAL, ~v[7:0]);
      wait_idle(); chk(rd[7], 1'b1);
      chk(dac_code, v);
      rd_reg(`DCS_OFF_DATAH); chk(rd, 0);
      wr(`DCS_OFF_CTRL, 8'h20); chk(pin, 1'b0);
      final_report();
   end
endmodule
